//--- iss_decoder.sv
`timescale 1ns/1ns
`include "iss_consts.svh"

module iss_decoder #(
    parameter int WORD_W = `ISS_WORD_W,
    parameter int OPC_W = `ISS_OPC_W
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input iss_pkg::iss_fetch_type fetch,
    input wire logic cond_true,
    output logic fetch_ready_q,
    output iss_pkg::iss_issue_type issue_q,
    output logic instr_done_q,
    output logic [`ISS_CYC_W-1:0] instr_cycles_q,
    output logic second_word_err_q,
    output logic illegal_op_q
);
    import iss_pkg::*;

    // the field layout is fixed, so other widths cannot be served
    initial begin
        if (WORD_W != `ISS_WORD_W || OPC_W != `ISS_OPC_W) begin
            $error("iss_decoder: unsupported word or opcode width");
        end
    end

    iss_state_type state_q;
    iss_state_type state_d;
    logic [`ISS_CYC_W-1:0] stall_q;
    logic [`ISS_CYC_W-1:0] stall_d;
    logic [`ISS_CYC_W-1:0] elapsed_q;
    logic [`ISS_CYC_W-1:0] elapsed_d;
    logic [`ISS_WORD_W-1:0] first_q;
    logic [`ISS_WORD_W-1:0] first_d;
    logic fetch_ready_d;
    iss_issue_type issue_d;
    logic instr_done_d;
    logic [`ISS_CYC_W-1:0] instr_cycles_d;
    logic second_word_err_d;
    logic illegal_op_d;

    iss_class_type cls;
    iss_operands_type ops;
    logic [`ISS_WORD_W-1:0] op_first;
    logic [`ISS_WORD_W-1:0] op_second;
    logic [`ISS_OPC_W-1:0] opc;

    assign opc = fetch.word[`ISS_OPC_MSB:`ISS_OPC_LSB];

    // one operand extractor serves both single words and joined double words
    assign op_first = (state_q == ST_SECOND) ? first_q : fetch.word;
    assign op_second = (state_q == ST_SECOND) ? fetch.word : '0;

    iss_classify u_classify (
        .word(fetch.word),
        .cls(cls)
    );

    iss_operands u_operands (
        .first_word(op_first),
        .second_word(op_second),
        .ops(ops)
    );

    function automatic iss_issue_type nop_issue();
        iss_issue_type n;
        n = '0;
        n.valid = 1'b1;
        n.nop = 1'b1;
        n.wr_en = 1'b0;
        nop_issue = n;
    endfunction : nop_issue

    always_comb begin
        state_d = state_q;
        stall_d = stall_q;
        elapsed_d = elapsed_q;
        first_d = first_q;
        fetch_ready_d = 1'b1;
        issue_d = '0;
        instr_done_d = 1'b0;
        instr_cycles_d = instr_cycles_q;
        second_word_err_d = 1'b0;
        illegal_op_d = 1'b0;
        case (state_q)
            ST_RUN: begin
                if (fetch.valid) begin
                    issue_d.valid = 1'b1;
                    issue_d.opcode = opc;
                    issue_d.category = cls.category;
                    issue_d.ops = ops;
                    issue_d.nop = cls.nop || cls.illegal;
                    issue_d.wr_en = cls.writes && !cls.nop && !cls.illegal;
                    illegal_op_d = cls.illegal;
                    elapsed_d = `ISS_CYC_ONE;
                    if (cls.double_word) begin
                        // first half is held; nothing issues until the pair is complete
                        issue_d = '0;
                        first_d = fetch.word;
                        state_d = ST_SECOND;
                    end else if (cls.skip && cond_true) begin
                        state_d = ST_SKIP;
                    end else if (cls.cond && cond_true) begin
                        issue_d.pc_change = 1'b1;
                        stall_d = `ISS_CYC_COND - `ISS_CYC_ONE - `ISS_CYC_ONE;
                        fetch_ready_d = 1'b0;
                        state_d = ST_STALL;
                    end else if (cls.pc_change) begin
                        issue_d.pc_change = 1'b1;
                        stall_d = cls.taken_cycles - `ISS_CYC_ONE - `ISS_CYC_ONE;
                        fetch_ready_d = 1'b0;
                        state_d = ST_STALL;
                    end else begin
                        instr_done_d = 1'b1;
                        instr_cycles_d = `ISS_CYC_ONE;
                    end
                end
            end
            ST_SECOND: begin
                if (fetch.valid) begin
                    issue_d.valid = 1'b1;
                    issue_d.opcode = first_q[`ISS_OPC_MSB:`ISS_OPC_LSB];
                    issue_d.category = first_q[`ISS_OPC_MSB:`ISS_OPC_LSB + `ISS_CAT_LSB];
                    issue_d.ops = ops;
                    // a second word with a nonzero top byte is rejected and the pair dropped
                    second_word_err_d = !iss_upper_zero(fetch.word);
                    issue_d.nop = second_word_err_d;
                    issue_d.wr_en = !second_word_err_d
                        && (first_q[`ISS_OPC_MSB:`ISS_OPC_LSB] == `ISS_OP_DW_MOVE);
                    issue_d.pc_change = !second_word_err_d
                        && (first_q[`ISS_OPC_MSB:`ISS_OPC_LSB] != `ISS_OP_DW_MOVE);
                    instr_done_d = 1'b1;
                    instr_cycles_d = `ISS_CYC_DW;
                    state_d = ST_RUN;
                end
            end
            ST_STALL: begin
                issue_d = nop_issue();
                elapsed_d = elapsed_q + `ISS_CYC_ONE;
                if (stall_q == '0) begin
                    instr_done_d = 1'b1;
                    instr_cycles_d = elapsed_q + `ISS_CYC_ONE;
                    state_d = ST_RUN;
                end else begin
                    stall_d = stall_q - `ISS_CYC_ONE;
                    fetch_ready_d = 1'b0;
                end
            end
            ST_SKIP: begin
                if (fetch.valid) begin
                    issue_d = nop_issue();
                    if (cls.double_word) begin
                        state_d = ST_SKIP2;
                    end else begin
                        instr_done_d = 1'b1;
                        instr_cycles_d = `ISS_CYC_SKIP1;
                        state_d = ST_RUN;
                    end
                end
            end
            ST_SKIP2: begin
                if (fetch.valid) begin
                    issue_d = nop_issue();
                    instr_done_d = 1'b1;
                    instr_cycles_d = `ISS_CYC_SKIP2;
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // clk_en is the instruction clock: with it low every flip-flop holds
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_RUN;
            stall_q <= '0;
            elapsed_q <= '0;
            first_q <= '0;
            fetch_ready_q <= 1'b1;
            issue_q <= '0;
            instr_done_q <= 1'b0;
            instr_cycles_q <= '0;
            second_word_err_q <= 1'b0;
            illegal_op_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            stall_q <= stall_d;
            elapsed_q <= elapsed_d;
            first_q <= first_d;
            fetch_ready_q <= fetch_ready_d;
            issue_q <= issue_d;
            instr_done_q <= instr_done_d;
            instr_cycles_q <= instr_cycles_d;
            second_word_err_q <= second_word_err_d;
            illegal_op_q <= illegal_op_d;
        end
    end

endmodule : iss_decoder

//--- iss_consts.svh
`ifndef ISS_CONSTS_SVH
`define ISS_CONSTS_SVH

// instruction word layout
`define ISS_WORD_W 24
`define ISS_OPC_W 8
`define ISS_OPC_MSB 23
`define ISS_OPC_LSB 16
`define ISS_OPD_W 16
`define ISS_CAT_MSB 7
`define ISS_CAT_LSB 5

// category codes held in the top three opcode bits
`define ISS_CAT_CTRL 3'h0
`define ISS_CAT_FILE 3'h1
`define ISS_CAT_WORKING_REGISTER_ZERO 3'h2
`define ISS_CAT_BIT 3'h3
`define ISS_CAT_LIT 3'h4

// control group opcodes
`define ISS_OP_NOP 8'h00
`define ISS_OP_BRANCH 8'h01
`define ISS_OP_CALL_IND 8'h02
`define ISS_OP_GOTO_IND 8'h03
`define ISS_OP_RETURN 8'h04
`define ISS_OP_INTRET 8'h05
`define ISS_OP_TBL_RD 8'h06
`define ISS_OP_TBL_WR 8'h07
`define ISS_OP_COND_BRANCH 8'h08
`define ISS_OP_SKIP 8'h09
`define ISS_OP_DW_GOTO 8'h0a
`define ISS_OP_DW_CALL 8'h0b
`define ISS_OP_DW_MOVE 8'h0c

// cycle counts
`define ISS_CYC_W 3
`define ISS_CYC_ONE 3'h1
`define ISS_CYC_COND 3'h2
`define ISS_CYC_BRANCH 3'h2
`define ISS_CYC_IND 3'h2
`define ISS_CYC_TABLE 3'h2
`define ISS_CYC_RETURN 3'h3
`define ISS_CYC_DW 3'h2
`define ISS_CYC_SKIP1 3'h2
`define ISS_CYC_SKIP2 3'h3

// working register operand fields
`define ISS_W_BASE_LSB 12
`define ISS_W_DMODE_LSB 10
`define ISS_W_DST_LSB 6
`define ISS_W_SMODE_LSB 4
`define ISS_W_SRC_LSB 0
`define ISS_REG_W 4
`define ISS_MODE_W 2

// file register operand fields
`define ISS_F_ADDR_W 13
`define ISS_F_DEST_BIT 13
`define ISS_F_BYTE_BIT 14

// bit operand fields
`define ISS_B_SEL_LSB 12
`define ISS_B_INDIRECT_BIT 11
`define ISS_B_ON_FILE_BIT 10
`define ISS_B_TGT_W 10

// literal operand fields
`define ISS_L_DST_PRESENT_BIT 11
`define ISS_L_DST_LSB 7
`define ISS_L_LIT_W 7

// control operand fields
`define ISS_PADDR_W 23
`define ISS_PADDR_HI_W 7
`define ISS_TMODE_LSB 14

`endif

//--- iss_pkg.sv
`include "iss_consts.svh"

package iss_pkg;

    typedef struct packed {
        logic valid;
        logic [`ISS_WORD_W-1:0] word;
    } iss_fetch_type;

    typedef struct packed {
        logic [2:0] category;
        logic double_word;
        logic nop;
        logic illegal;
        logic cond;
        logic skip;
        logic pc_change;
        logic [`ISS_CYC_W-1:0] taken_cycles;
        logic writes;
    } iss_class_type;

    typedef struct packed {
        logic [`ISS_REG_W-1:0] base_source_register;
        logic [`ISS_REG_W-1:0] second_source_register;
        logic [`ISS_MODE_W-1:0] src_mode;
        logic [`ISS_REG_W-1:0] destination_register;
        logic [`ISS_MODE_W-1:0] dst_mode;
        logic [`ISS_F_ADDR_W-1:0] file_addr;
        logic dest_is_file;
        logic byte_mode;
        logic [`ISS_REG_W-1:0] bit_sel;
        logic bit_from_base;
        logic bit_on_file;
        logic [`ISS_OPD_W-1:0] literal;
        logic [`ISS_PADDR_W-1:0] prog_addr;
        logic [`ISS_MODE_W-1:0] table_mode;
    } iss_operands_type;

    typedef struct packed {
        logic valid;
        logic nop;
        logic [`ISS_OPC_W-1:0] opcode;
        logic [2:0] category;
        logic wr_en;
        logic pc_change;
        iss_operands_type ops;
    } iss_issue_type;

    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_SECOND = 5'b00010,
        ST_STALL = 5'b00100,
        ST_SKIP = 5'b01000,
        ST_SKIP2 = 5'b10000
    } iss_state_type;

    function automatic logic iss_upper_zero(input logic [`ISS_WORD_W-1:0] w);
        iss_upper_zero = (w[`ISS_OPC_MSB:`ISS_OPC_LSB] == `ISS_OP_NOP);
    endfunction : iss_upper_zero

    function automatic logic iss_is_double(input logic [`ISS_OPC_W-1:0] opc);
        iss_is_double = (opc == `ISS_OP_DW_GOTO) || (opc == `ISS_OP_DW_CALL) || (opc == `ISS_OP_DW_MOVE);
    endfunction : iss_is_double

endpackage : iss_pkg

//--- iss_classify.sv
`timescale 1ns/1ns
`include "iss_consts.svh"

module iss_classify (
    input wire logic [`ISS_WORD_W-1:0] word,
    output iss_pkg::iss_class_type cls
);
    import iss_pkg::*;

    logic [`ISS_OPC_W-1:0] opc;

    assign opc = word[`ISS_OPC_MSB:`ISS_OPC_LSB];

    always_comb begin
        cls = '0;
        cls.category = opc[`ISS_CAT_MSB:`ISS_CAT_LSB];
        cls.double_word = iss_is_double(opc);
        cls.nop = iss_upper_zero(word);
        cls.taken_cycles = `ISS_CYC_ONE;
        case (opc[`ISS_CAT_MSB:`ISS_CAT_LSB])
            `ISS_CAT_CTRL: begin
                case (opc)
                    `ISS_OP_NOP, `ISS_OP_DW_GOTO, `ISS_OP_DW_CALL: begin
                        cls.writes = 1'b0;
                    end
                    `ISS_OP_DW_MOVE: begin
                        cls.writes = 1'b1;
                    end
                    `ISS_OP_BRANCH: begin
                        cls.pc_change = 1'b1;
                        cls.taken_cycles = `ISS_CYC_BRANCH;
                    end
                    `ISS_OP_CALL_IND, `ISS_OP_GOTO_IND: begin
                        cls.pc_change = 1'b1;
                        cls.taken_cycles = `ISS_CYC_IND;
                        cls.writes = (opc == `ISS_OP_CALL_IND);
                    end
                    `ISS_OP_RETURN, `ISS_OP_INTRET: begin
                        cls.pc_change = 1'b1;
                        cls.taken_cycles = `ISS_CYC_RETURN;
                        cls.writes = 1'b1;
                    end
                    `ISS_OP_TBL_RD, `ISS_OP_TBL_WR: begin
                        cls.pc_change = 1'b1;
                        cls.taken_cycles = `ISS_CYC_TABLE;
                        cls.writes = 1'b1;
                    end
                    `ISS_OP_COND_BRANCH: begin
                        cls.cond = 1'b1;
                        cls.taken_cycles = `ISS_CYC_COND;
                    end
                    `ISS_OP_SKIP: begin
                        cls.skip = 1'b1;
                    end
                    default: begin
                        cls.illegal = 1'b1;
                    end
                endcase
            end
            `ISS_CAT_FILE, `ISS_CAT_WORKING_REGISTER_ZERO, `ISS_CAT_BIT, `ISS_CAT_LIT: begin
                cls.writes = 1'b1;
            end
            default: begin
                cls.illegal = 1'b1;
            end
        endcase
    end

endmodule : iss_classify

//--- iss_operands.sv
`timescale 1ns/1ns
`include "iss_consts.svh"

module iss_operands (
    input wire logic [`ISS_WORD_W-1:0] first_word,
    input wire logic [`ISS_WORD_W-1:0] second_word,
    output iss_pkg::iss_operands_type ops
);
    import iss_pkg::*;

    logic [`ISS_OPC_W-1:0] opc;
    logic [`ISS_OPD_W-1:0] f;
    logic [`ISS_OPD_W-1:0] s;

    assign opc = first_word[`ISS_OPC_MSB:`ISS_OPC_LSB];
    assign f = first_word[`ISS_OPD_W-1:0];
    assign s = second_word[`ISS_OPD_W-1:0];

    always_comb begin
        ops = '0;
        case (opc[`ISS_CAT_MSB:`ISS_CAT_LSB])
            `ISS_CAT_FILE: begin
                ops.file_addr = f[`ISS_F_ADDR_W-1:0];
                ops.dest_is_file = f[`ISS_F_DEST_BIT];
                ops.byte_mode = f[`ISS_F_BYTE_BIT];
            end
            `ISS_CAT_WORKING_REGISTER_ZERO: begin
                ops.base_source_register = f[`ISS_W_BASE_LSB +: `ISS_REG_W];
                ops.second_source_register = f[`ISS_W_SRC_LSB +: `ISS_REG_W];
                ops.src_mode = f[`ISS_W_SMODE_LSB +: `ISS_MODE_W];
                ops.destination_register = f[`ISS_W_DST_LSB +: `ISS_REG_W];
                ops.dst_mode = f[`ISS_W_DMODE_LSB +: `ISS_MODE_W];
            end
            `ISS_CAT_BIT: begin
                ops.bit_from_base = f[`ISS_B_INDIRECT_BIT];
                ops.bit_sel = f[`ISS_B_SEL_LSB +: `ISS_REG_W];
                ops.base_source_register = f[`ISS_B_SEL_LSB +: `ISS_REG_W];
                ops.bit_on_file = f[`ISS_B_ON_FILE_BIT];
                ops.file_addr = {3'h0, f[`ISS_B_TGT_W-1:0]};
                ops.second_source_register = f[`ISS_REG_W-1:0];
            end
            `ISS_CAT_LIT: begin
                ops.base_source_register = f[`ISS_W_BASE_LSB +: `ISS_REG_W];
                ops.literal = {9'h000, f[`ISS_L_LIT_W-1:0]};
                // without its own destination the result lands back in the base register
                ops.destination_register = f[`ISS_L_DST_PRESENT_BIT] ? f[`ISS_L_DST_LSB +: `ISS_REG_W]
                                                                    : f[`ISS_W_BASE_LSB +: `ISS_REG_W];
            end
            default: begin
                ops.prog_addr = {s[`ISS_PADDR_HI_W-1:0], f};
                ops.table_mode = f[`ISS_TMODE_LSB +: `ISS_MODE_W];
                ops.literal = f;
                ops.destination_register = s[`ISS_REG_W-1:0];
            end
        endcase
    end

endmodule : iss_operands

//--- iss_decoder_sva.sv
`timescale 1ns/1ns
`include "iss_consts.svh"

module iss_decoder_sva #(
    parameter int WORD_W = `ISS_WORD_W,
    parameter int OPC_W = `ISS_OPC_W
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input iss_pkg::iss_fetch_type fetch,
    input wire logic cond_true,
    input wire logic fetch_ready_q,
    input iss_pkg::iss_issue_type issue_q,
    input wire logic instr_done_q,
    input wire logic [`ISS_CYC_W-1:0] instr_cycles_q,
    input wire logic second_word_err_q,
    input wire logic illegal_op_q
);
    import iss_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // table ops are left out, though iss_classify sets pc_change for them too
    wire jump = issue_q.valid && issue_q.pc_change && issue_q.opcode inside {[8'h01:8'h05], 8'h08};
    wire ret = issue_q.valid && issue_q.pc_change && issue_q.opcode inside {8'h04, 8'h05};

    a_nop_no_write: assert property (issue_q.valid && issue_q.nop |-> !issue_q.wr_en)
        else $error("nop issue writes");
    a_single_one_cycle: assert property (issue_q.valid && !issue_q.nop
        && issue_q.category inside {[3'h1:3'h4]} |-> instr_done_q && instr_cycles_q == 3'h1)
        else $error("single op not one cycle");
    a_dw_two_cycles: assert property (issue_q.valid && !issue_q.nop
        && issue_q.opcode inside {[8'h0a:8'h0c]} |-> instr_done_q && instr_cycles_q == 3'h2)
        else $error("pair not two cycles");
    a_jump_then_nop: assert property (jump && clk_en |-> !instr_done_q ##1 issue_q.valid && issue_q.nop)
        else $error("no nop after jump");
    a_return_three: assert property (ret && clk_en ##1 clk_en |=> instr_done_q && instr_cycles_q == 3'h3)
        else $error("return not three cycles");
    a_stall_one: assert property (jump && !ret && clk_en |=> fetch_ready_q)
        else $error("stall too long");
    a_stall_cause: assert property ($fell(fetch_ready_q) |-> issue_q.valid && issue_q.pc_change)
        else $error("stall without jump");
    a_err_pair_nop: assert property (second_word_err_q |-> issue_q.nop && instr_done_q && instr_cycles_q == 3'h2)
        else $error("bad pair not nop");
    a_illegal_nop: assert property (illegal_op_q |-> issue_q.valid && issue_q.nop)
        else $error("illegal op not nop");
    a_freeze_hold: assert property (!clk_en |=> $stable(issue_q) && $stable(fetch_ready_q))
        else $error("state moved while frozen");

    c_return: cover property (ret ##1 !fetch_ready_q);
    c_bad_pair: cover property (second_word_err_q);
    c_illegal: cover property (illegal_op_q);
endmodule : iss_decoder_sva

bind iss_decoder iss_decoder_sva #(.WORD_W(WORD_W), .OPC_W(OPC_W)) i_iss_decoder_sva (.ref_clk(ref_clk),
    .resetn(resetn), .clk_en(clk_en), .fetch(fetch), .cond_true(cond_true), .fetch_ready_q(fetch_ready_q),
    .issue_q(issue_q), .instr_done_q(instr_done_q), .instr_cycles_q(instr_cycles_q),
    .second_word_err_q(second_word_err_q), .illegal_op_q(illegal_op_q));

//--- iss_prog_mem.sv
`timescale 1ns/1ns
`include "iss_consts.svh"

module iss_prog_mem (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic slow,
    input wire logic fetch_ready_q,
    output iss_pkg::iss_fetch_type fetch,
    output logic cond_true
);
    import iss_pkg::*;
    logic [`ISS_WORD_W:0] mem [512];
    int count = 0;
    int ptr = 0;
    logic hold;
    initial begin
        fetch = '0;
        cond_true = 1'b0;
    end
    // a word stays up until taken; idle lines toggle so stale data never looks new
    always @(posedge ref_clk) begin
        hold = fetch.valid && !(clk_en && fetch_ready_q);
        if (!resetn) ptr = 0;
        else if (fetch.valid && !hold) ptr = ptr + 1;
        #1;
        if (resetn && ptr < count && (hold || !slow)) begin
            {cond_true, fetch.word} = mem[ptr];
            fetch.valid = 1'b1;
        end else begin
            {cond_true, fetch.word} = ~{cond_true, fetch.word};
            fetch.valid = 1'b0;
        end
    end
endmodule : iss_prog_mem

//--- tb.sv
`timescale 1ns/1ns
`include "iss_consts.svh"

module tb;
    import iss_pkg::*;
    logic ref_clk;
    logic resetn;
    logic clk_en;
    logic slow;
    iss_fetch_type fetch;
    logic cond_true;
    logic fetch_ready_q;
    iss_issue_type issue_q;
    logic instr_done_q;
    logic [`ISS_CYC_W-1:0] instr_cycles_q;
    logic second_word_err_q;
    logic illegal_op_q;
    int bad_count;
    int n_compared;
    int en_pct;
    int n_ill;
    int n_err;
    int exp_ill;
    int exp_err;
    logic [31:0] seed;
    logic [`ISS_WORD_W:0] prog[$];
    logic [2:0] exp_q[$];
    logic [2:0] got_q[$];
    logic [`ISS_WORD_W-1:0] last_w;
    logic [`ISS_WORD_W-1:0] prev_w;

    iss_decoder i_iss_decoder (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .fetch(fetch),
        .cond_true(cond_true), .fetch_ready_q(fetch_ready_q), .issue_q(issue_q), .instr_done_q(instr_done_q),
        .instr_cycles_q(instr_cycles_q), .second_word_err_q(second_word_err_q), .illegal_op_q(illegal_op_q));
    iss_prog_mem i_iss_prog_mem (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .slow(slow),
        .fetch_ready_q(fetch_ready_q), .fetch(fetch), .cond_true(cond_true));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    always @(posedge ref_clk) begin
        #1;
        clk_en <= (xs() % 100) < en_pct;
        slow <= (xs() % 4) == 0;
    end

    // issue at an enabled edge belongs to the word taken at the enabled edge before
    always @(posedge ref_clk) begin
        if (resetn && clk_en) begin
            if (instr_done_q === 1'b1 && illegal_op_q !== 1'b1) got_q.push_back(instr_cycles_q);
            if (illegal_op_q === 1'b1) n_ill++;
            if (second_word_err_q === 1'b1) n_err++;
            if (issue_q.valid === 1'b1 && issue_q.nop === 1'b0) begin
                case (issue_q.category)
                    3'h1: chk("file_addr", 32'(last_w[13:0]), {issue_q.ops.dest_is_file, issue_q.ops.file_addr});
                    3'h2: chk("w_fields", 32'({last_w[15:12], last_w[9:6], last_w[3:0]}),
                        {issue_q.ops.base_source_register, issue_q.ops.destination_register,
                        issue_q.ops.second_source_register});
                    3'h3: chk("bit_src", 32'(last_w[11]), 32'(issue_q.ops.bit_from_base));
                    3'h4: chk("lit_dst", 32'(last_w[11] ? last_w[10:7] : last_w[15:12]),
                        32'(issue_q.ops.destination_register));
                    default: if (issue_q.opcode === 8'h0a)
                        chk("prog_addr", 32'({last_w[6:0], prev_w[15:0]}), 32'(issue_q.ops.prog_addr));
                    else if (issue_q.opcode inside {8'h06, 8'h07})
                        chk("table_mode", 32'(last_w[15:14]), 32'(issue_q.ops.table_mode));
                endcase
                if (issue_q.category !== 3'h0) chk("opcode", 32'(last_w[23:16]), 32'(issue_q.opcode));
            end
            if (issue_q.valid === 1'b1 && issue_q.nop === 1'b1) chk("nop_wr_en", 0, 32'(issue_q.wr_en));
            if (fetch.valid && fetch_ready_q) begin
                prev_w <= last_w;
                last_w <= fetch.word;
            end
        end
    end

    function automatic void build_expect();
        int i;
        logic [7:0] op;
        logic [7:0] nx;
        logic [2:0] c;
        exp_q.delete();
        exp_ill = 0;
        exp_err = 0;
        i = 0;
        while (i < prog.size()) begin
            op = prog[i][23:16];
            nx = (i + 1 < prog.size()) ? prog[i+1][23:16] : 8'h00;
            case (op)
                8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0a, 8'h0b, 8'h0c: c = 3'h2;
                8'h04, 8'h05: c = 3'h3;
                8'h08: c = prog[i][24] ? 3'h2 : 3'h1;
                8'h09: c = !prog[i][24] ? 3'h1 : (nx inside {[8'h0a:8'h0c]}) ? 3'h3 : 3'h2;
                default: c = 3'h1;
            endcase
            if (op[7:5] > 3'h4 || (op[7:5] == 3'h0 && op > 8'h0c)) exp_ill++;
            else exp_q.push_back(c);
            if (op inside {[8'h0a:8'h0c]} && nx != 8'h00) exp_err++;
            i += (op inside {[8'h0a:8'h0c]}) ? 2 : (c == 3'h1 || op != 8'h09) ? 1 : c;
        end
    endfunction : build_expect

    task automatic gen(input int n);
        logic [31:0] r;
        logic [2:0] cat;
        logic [7:0] op;
        repeat (n) begin
            r = xs();
            cat = (r[2:0] > 3'h4) ? 3'h0 : r[2:0];
            op = (cat != 3'h0) ? {cat, r[7:3]} : (r[11:8] > 4'hc) ? 8'h09 : {4'h0, r[11:8]};
            prog.push_back({r[31], op, r[27:12]});
            if (op inside {[8'h0a:8'h0c]}) prog.push_back({1'b0, 8'h00, r[15:0]});
        end
        prog.push_back(25'h0200000);
    endtask : gen

    task automatic run(input int pct);
        int k;
        build_expect();
        got_q.delete();
        n_ill = 0;
        n_err = 0;
        en_pct = pct;
        resetn = 1'b0;
        foreach (prog[j]) i_iss_prog_mem.mem[j] = prog[j];
        i_iss_prog_mem.count = prog.size();
        repeat (6) @(posedge ref_clk);
        #1 resetn = 1'b1;
        k = 0;
        while (i_iss_prog_mem.ptr < prog.size() && k < 5000) begin
            @(posedge ref_clk);
            k++;
        end
        repeat (40) @(posedge ref_clk);
        if (k == 5000) begin
            chk("timeout", 0, 1);
            summarize();
        end
        chk("done count", exp_q.size(), got_q.size());
        foreach (exp_q[j]) if (j < got_q.size()) chk("cycles", exp_q[j], got_q[j]);
        chk("illegal", exp_ill, n_ill);
        chk("second word err", exp_err, n_err);
        $display("test done, %0d instructions, enable %0d percent", exp_q.size(), pct);
        #1;
    endtask : run

    initial begin
        seed = 32'h764d292c;
        bad_count = 0;
        n_compared = 0;
        resetn = 1'b0;
        clk_en = 1'b1;
        slow = 1'b0;
        en_pct = 100;
        last_w = '0;
        prev_w = '0;
        prog = {25'h0040000, 25'h0040000, 25'h0050000, 25'h0010000, 25'h0020000, 25'h0030000, 25'h1080000,
            25'h0080000, 25'h1090000, 25'h02a1234, 25'h1090000, 25'h00b1234, 25'h0000045, 25'h0090000,
            25'h0216abc, 25'h00a5678, 25'h0000012, 25'h00c00ff, 25'h0000003, 25'h0000077, 25'h006c000,
            25'h0074000, 25'h00b1111, 25'h0120005, 25'h045f3c7, 25'h0631c55, 25'h0843f81, 25'h085a07f,
            25'h00d0000, 25'h0a00000, 25'h0e50000, 25'h0200000};
        run(100);
        prog.delete();
        gen(150);
        run(100);
        prog.delete();
        gen(150);
        run(70);
        summarize();
    end
endmodule : tb
